// >>> rtl/rtc_pkg.sv
// shared constants, types and encodings of the timekeeper core
package rtc_pkg;
  // clock rate and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int XTAL_DIV_DEF = 32768;
  localparam int NV_WC_MS = 10;
  localparam int NV_WC_CYC = NV_WC_MS * (CLK_HZ / 1000);
  // device select code, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h6F;
  // bit slots within one byte frame
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  // address map sections (address bits 5:3) and offsets within a section
  localparam logic [2:0] SEC_ALM0 = 3'h0;
  localparam logic [2:0] SEC_ALM1 = 3'h1;
  localparam logic [2:0] SEC_CTRL = 3'h2;
  localparam logic [2:0] SEC_RTC = 3'h6;
  localparam logic [2:0] SEC_STAT = 3'h7;
  localparam logic [2:0] IDX_SEC = 3'h0;
  localparam logic [2:0] IDX_MIN = 3'h1;
  localparam logic [2:0] IDX_HR = 3'h2;
  localparam logic [2:0] IDX_DT = 3'h3;
  localparam logic [2:0] IDX_MO = 3'h4;
  localparam logic [2:0] IDX_YR = 3'h5;
  localparam logic [2:0] IDX_DOW = 3'h6;
  localparam logic [2:0] IDX_STAT = 3'h7;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  // field positions
  localparam int HR_MIL = 7;
  localparam int HR_PM = 5;
  localparam int ALM_EN = 7;
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_REPEAT = 6;
  localparam int SR_BAT = 7;
  localparam int SR_AL1 = 6;
  localparam int SR_AL0 = 5;
  localparam int SR_RWEL = 2;
  localparam int SR_WEL = 1;
  localparam int SR_RTCF = 0;
  // status write codes
  localparam logic [7:0] SR_SET_WEL = 8'h02;
  localparam logic [7:0] SR_SET_RWEL = 8'h06;
  localparam logic [7:0] SR_CLEAR = 8'h00;
  // bcd limits and month codes
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [5:0] HR24_LAST = 6'h23;
  localparam logic [4:0] HR12_TOP = 5'h12;
  localparam logic [4:0] HR12_LAST = 5'h11;
  localparam logic [4:0] HR12_FIRST = 5'h01;
  localparam logic [2:0] DOW_LAST = 3'h6;
  localparam logic [7:0] MO_FEB = 8'h02;
  localparam logic [7:0] MO_APR = 8'h04;
  localparam logic [7:0] MO_JUN = 8'h06;
  localparam logic [7:0] MO_SEP = 8'h09;
  localparam logic [7:0] MO_NOV = 8'h11;
  localparam logic [7:0] MO_DEC = 8'h12;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  // eight byte bank: one section of the map
  typedef logic [7:0][7:0] bank_t;
  // reset time: 12 AM, date 01, month 01, year 00, weekday 0
  localparam bank_t TM_RESET = {8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h12, 8'h00, 8'h00};
  // serial engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEVA = 6'h02,
    ST_ADRH = 6'h04,
    ST_ADRL = 6'h08,
    ST_WDAT = 6'h10,
    ST_RDAT = 6'h20
  } link_st_e;
  // supply comparator inputs
  typedef struct packed {
    logic below;
    logic above;
  } pwr_cmp_s;
  // open-drain pin drivers
  typedef struct packed {
    logic sda_o;
    logic sda_oe_n;
    logic irq_o;
    logic irq_oe_n;
  } od_pins_s;
endpackage

// >>> rtl/rtc_timekeeper.sv
// timekeeper core with serial snapshot/commit port, alarms and supply switch
// Function
// - nonvolatile write is self-timed from stop; busy device refuses select
// - two alarms compare enabled fields against running time
// - alarm shows as sticky status flag and optionally on interrupt
// - repeat mode lets an alarm fire again each match
// - interrupt pin pulled low while an alarm flag stands with interrupt enabled, otherwise released
// - run from backup below threshold, back to main when main exceeds backup
// - crystal base keeps second, minute, hour, weekday, date, month, year
// - date rolls per month length with February leap correction
// - hour format bit selects 24-hour or 12-hour with meridiem
// - after total power loss clock stays stopped until clock written
// - time copied to read latch at ack fall before read data
// - counters and alarms keep running during reads
// - clock read by addressing a clock register, then sequential bytes
// - time copied to write buffer at ack fall before write data
// - buffer goes to counters only on stop ending valid write
// - invalid write discards buffer, running time untouched
// - newly written time appears at next one-second tick
// - counters run during writes and nonvolatile cycles
// - single byte write changes only that byte
// - all serial data shifted with serial clock, input never gated
// - registers hold bcd values in their documented ranges
// - hours 0-23 in 24-hour mode, 1-12 with meridiem otherwise
// - weekday is three bits cycling 0 to 6, default 0
`timescale 1ns/1ps
module rtc_timekeeper #(
  parameter int XTAL_DIV = rtc_pkg::XTAL_DIV_DEF,
  parameter int NV_CYCLES = rtc_pkg::NV_WC_CYC,
  parameter logic [6:0] DEV_ADDR = rtc_pkg::DEV_ADDR_DEF
) (
  // system clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial link
  input wire logic SCL,
  input wire logic SDA_I,
  // crystal amplifier
  input wire logic CRYSTAL_AMP_IN,
  output logic CRYSTAL_AMP_OUT,
  // supply comparators and selection
  input rtc_pkg::pwr_cmp_s PWR_CMP,
  output logic BAT_SEL,
  // open-drain drivers
  output rtc_pkg::od_pins_s OD_PINS
);
  import rtc_pkg::*;

  localparam int PW = $clog2(XTAL_DIV);
  localparam int NW = $clog2(NV_CYCLES + 1);

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] xtl_s;
    logic [1:0] blw_s;
    logic [1:0] abv_s;
    logic scl_q;
    logic sda_q;
    logic xtl_q;
    logic [PW-1:0] presc;
    bank_t tm;
    bank_t rdl;
    bank_t wbuf;
    bank_t tpend;
    bank_t alm0;
    bank_t alm1;
    logic [7:0] ctrl;
    logic commit_pend;
    logic rtcf;
    logic wel;
    logic rwel;
    logic bat;
    logic [1:0] al;
    logic [1:0] armed;
    logic [1:0] al_mask;
    link_st_e st;
    link_st_e nst;
    logic [3:0] bitn;
    logic [5:0] addr;
    logic [7:0] txb;
    logic ack_pend;
    logic wr_ok;
    logic wr_any;
    logic nvbusy;
    logic [NW-1:0] nvcnt;
    logic sda_oe_n;
    logic irq_oe_n;
    logic xo;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [7:0] rx_sh_r;

  function automatic logic [7:0] bcd_inc(input logic [7:0] b);
    logic [7:0] r;
    if (b[3:0] == 4'h9) begin
      r = {b[7:4] + 4'h1, 4'h0};
    end else begin
      r = {b[7:4], b[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                   (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mo == MO_FEB) begin
      r = leap ? DAYS_29 : DAYS_28;
    end else if (mo == MO_APR || mo == MO_JUN || mo == MO_SEP || mo == MO_NOV) begin
      r = DAYS_30;
    end else begin
      r = DAYS_31;
    end
    return r;
  endfunction

  function automatic bank_t advance(input bank_t t);
    bank_t n;
    logic [7:0] h;
    logic [7:0] inc;
    logic day;
    n = t;
    h = t[IDX_HR];
    day = 1'b0;
    inc = 8'h00;
    // bcd seconds and minutes wrap at 59
    if (t[IDX_SEC] != BCD_59) begin
      n[IDX_SEC] = bcd_inc(t[IDX_SEC]);
    end else begin
      n[IDX_SEC] = 8'h00;
      if (t[IDX_MIN] != BCD_59) begin
        n[IDX_MIN] = bcd_inc(t[IDX_MIN]);
      end else begin
        n[IDX_MIN] = 8'h00;
        if (h[HR_MIL]) begin
          if (h[5:0] == HR24_LAST) begin
            n[IDX_HR] = {h[7:6], 6'h00};
            day = 1'b1;
          end else begin
            inc = bcd_inc({2'b00, h[5:0]});
            n[IDX_HR] = {h[7:6], inc[5:0]};
          end
        end else begin
          if (h[4:0] == HR12_TOP) begin
            n[IDX_HR] = {h[7:5], HR12_FIRST};
          end else if (h[4:0] == HR12_LAST) begin
            n[IDX_HR] = {h[7:6], ~h[HR_PM], HR12_TOP};
            day = h[HR_PM];
          end else begin
            inc = bcd_inc({3'b000, h[4:0]});
            n[IDX_HR] = {h[7:5], inc[4:0]};
          end
        end
      end
    end
    if (day) begin
      n[IDX_DOW] = (t[IDX_DOW][2:0] == DOW_LAST) ? 8'h00 : {5'h00, t[IDX_DOW][2:0] + 3'h1};
      if (t[IDX_DT] != month_len(t[IDX_MO], t[IDX_YR])) begin
        n[IDX_DT] = bcd_inc(t[IDX_DT]);
      end else begin
        n[IDX_DT] = BCD_ONE;
        if (t[IDX_MO] != MO_DEC) begin
          n[IDX_MO] = bcd_inc(t[IDX_MO]);
        end else begin
          n[IDX_MO] = BCD_ONE;
          n[IDX_YR] = (t[IDX_YR] == BCD_99) ? 8'h00 : bcd_inc(t[IDX_YR]);
        end
      end
    end
    return n;
  endfunction

  function automatic logic alarm_hit(input bank_t a, input bank_t t);
    logic any_en;
    logic all_eq;
    any_en = 1'b0;
    all_eq = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i != int'(IDX_YR) && a[i][ALM_EN]) begin
        any_en = 1'b1;
        if (a[i][6:0] != t[i][6:0]) begin
          all_eq = 1'b0;
        end
      end
    end
    return any_en & all_eq;
  endfunction

  function automatic logic [7:0] rd_byte(input state_s s, input logic [5:0] a, input bank_t rtc);
    logic [7:0] r;
    r = 8'h00;
    unique case (a[5:3])
      SEC_ALM0: r = s.alm0[a[2:0]];
      SEC_ALM1: r = s.alm1[a[2:0]];
      SEC_CTRL: r = (a[2:0] == IDX_CTRL) ? s.ctrl : 8'h00;
      SEC_RTC: r = rtc[a[2:0]];
      SEC_STAT: begin
        if (a[2:0] == IDX_STAT) begin
          r[SR_BAT] = s.bat;
          r[SR_AL1] = s.al[1];
          r[SR_AL0] = s.al[0];
          r[SR_RWEL] = s.rwel;
          r[SR_WEL] = s.wel;
          r[SR_RTCF] = s.rtcf;
        end
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // receive shifter clocked by the serial clock itself
  always_ff @(posedge SCL or negedge RST_N) begin
    if (!RST_N) begin
      rx_sh_r <= 8'h00;
    end else begin
      rx_sh_r <= {rx_sh_r[6:0], SDA_I};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic xtl_rise;
  logic tick;
  logic [1:0] hit;
  logic [5:0] addr_inc;
  logic [2:0] sec;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], SCL};
    s_nxt.sda_s = {s_r.sda_s[0], SDA_I};
    s_nxt.xtl_s = {s_r.xtl_s[0], CRYSTAL_AMP_IN};
    s_nxt.blw_s = {s_r.blw_s[0], PWR_CMP.below};
    s_nxt.abv_s = {s_r.abv_s[0], PWR_CMP.above};
    s_nxt.scl_q = s_r.scl_s[1];
    s_nxt.sda_q = s_r.sda_s[1];
    s_nxt.xtl_q = s_r.xtl_s[1];
    s_nxt.xo = ~s_r.xtl_s[1];
    scl_rise = s_r.scl_s[1] & ~s_r.scl_q;
    scl_fall = ~s_r.scl_s[1] & s_r.scl_q;
    start_c = s_r.scl_s[1] & s_r.scl_q & s_r.sda_q & ~s_r.sda_s[1];
    stop_c = s_r.scl_s[1] & s_r.scl_q & ~s_r.sda_q & s_r.sda_s[1];
    xtl_rise = s_r.xtl_s[1] & ~s_r.xtl_q;
    addr_inc = {s_r.addr[5:3], s_r.addr[2:0] + 3'h1};
    sec = s_r.addr[5:3];
    hit = 2'b00;

    if (s_r.blw_s[1]) begin
      s_nxt.bat = 1'b1;
    end else if (s_r.abv_s[1]) begin
      s_nxt.bat = 1'b0;
    end

    // free-running prescaler, held while clock is stopped
    tick = 1'b0;
    if (s_r.rtcf) begin
      s_nxt.presc = '0;
    end else if (xtl_rise) begin
      if (s_r.presc == PW'(XTAL_DIV - 1)) begin
        s_nxt.presc = '0;
        tick = 1'b1;
      end else begin
        s_nxt.presc = s_r.presc + PW'(1);
      end
    end

    // counters advance each second; regardless of link activity
    if (tick) begin
      // committed time takes effect at the tick
      s_nxt.tm = s_r.commit_pend ? s_r.tpend : advance(s_r.tm);
      s_nxt.commit_pend = 1'b0;
      // alarm compare on the new time
      hit[0] = s_r.armed[0] & alarm_hit(s_r.alm0, s_nxt.tm);
      hit[1] = s_r.armed[1] & alarm_hit(s_r.alm1, s_nxt.tm);
      // without repeat an alarm fires once
      if (!s_r.ctrl[CTRL_REPEAT]) begin
        s_nxt.armed = s_r.armed & ~hit;
      end
    end

    if (s_r.nvbusy) begin
      if (s_r.nvcnt == NW'(NV_CYCLES - 1)) begin
        s_nxt.nvbusy = 1'b0;
        s_nxt.rwel = 1'b0;
      end else begin
        s_nxt.nvcnt = s_r.nvcnt + NW'(1);
      end
    end

    // link events seen through two-stage synchronisers only
    if (start_c) begin
      s_nxt.st = ST_DEVA;
      s_nxt.bitn = BIT_ZERO;
      s_nxt.sda_oe_n = 1'b1;
      s_nxt.wr_any = 1'b0;
    end else if (stop_c) begin
      // commit only on stop after a valid write; otherwise dropped
      if (s_r.st == ST_WDAT && s_r.wr_any && s_r.wr_ok && (sec == SEC_STAT || (s_r.wel && s_r.rwel))) begin
        unique case (sec)
          SEC_STAT: begin
            if (s_r.wbuf[IDX_STAT] == SR_SET_WEL) begin
              s_nxt.wel = 1'b1;
              s_nxt.rwel = 1'b0;
            end else if (s_r.wbuf[IDX_STAT] == SR_SET_RWEL && s_r.wel) begin
              s_nxt.rwel = 1'b1;
            end else if (s_r.wbuf[IDX_STAT] == SR_CLEAR) begin
              s_nxt.wel = 1'b0;
              s_nxt.rwel = 1'b0;
            end
          end
          SEC_RTC: begin
            // a clock write restarts a stopped clock
            s_nxt.tpend = s_r.wbuf;
            s_nxt.commit_pend = 1'b1;
            s_nxt.rtcf = 1'b0;
          end
          SEC_ALM0, SEC_ALM1, SEC_CTRL: begin
            if (sec == SEC_ALM0) begin
              s_nxt.alm0 = s_r.wbuf;
              s_nxt.armed[0] = 1'b1;
            end else if (sec == SEC_ALM1) begin
              s_nxt.alm1 = s_r.wbuf;
              s_nxt.armed[1] = 1'b1;
            end else begin
              s_nxt.ctrl = s_r.wbuf[IDX_CTRL];
            end
            s_nxt.nvbusy = 1'b1;
            s_nxt.nvcnt = '0;
          end
          default: s_nxt.wr_ok = 1'b0;
        endcase
      end
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end else if (s_r.st != ST_IDLE && scl_rise) begin
      s_nxt.bitn = s_r.bitn + 4'h1;
      if (s_r.bitn + 4'h1 == BIT_LAST && s_r.st != ST_RDAT) begin
        s_nxt.ack_pend = 1'b1;
        unique case (s_r.st)
          ST_DEVA: begin
            // busy device does not answer its select code
            if (rx_sh_r[7:1] != DEV_ADDR || s_r.nvbusy) begin
              s_nxt.ack_pend = 1'b0;
              s_nxt.nst = ST_IDLE;
            end else begin
              s_nxt.nst = rx_sh_r[0] ? ST_RDAT : ST_ADRH;
            end
          end
          ST_ADRH: s_nxt.nst = ST_ADRL;
          ST_ADRL: begin
            s_nxt.addr = rx_sh_r[5:0];
            s_nxt.nst = ST_WDAT;
            s_nxt.wr_ok = 1'b1;
          end
          default: begin
            // only the addressed buffer byte is replaced
            if (sec == SEC_STAT ? s_r.wr_any : !s_r.wel) begin
              s_nxt.ack_pend = 1'b0;
              s_nxt.wr_ok = 1'b0;
              s_nxt.nst = ST_IDLE;
            end else begin
              s_nxt.wbuf[s_r.addr[2:0]] = rx_sh_r;
              s_nxt.addr = addr_inc;
              s_nxt.wr_any = 1'b1;
            end
          end
        endcase
      end
      if (s_r.bitn + 4'h1 == BIT_ACK && s_r.st == ST_RDAT) begin
        // outside the status section, master acknowledge decides whether reading continues
        s_nxt.nst = (s_r.sda_s[1] || sec == SEC_STAT) ? ST_IDLE : ST_RDAT;
      end
    end else if (s_r.st != ST_IDLE && scl_fall) begin
      if (s_r.bitn == BIT_LAST) begin
        s_nxt.sda_oe_n = (s_r.st == ST_RDAT) ? 1'b1 : ~s_r.ack_pend;
        // status read clears only flags seen when it began
        if (s_r.st == ST_RDAT && sec == SEC_STAT) begin
          s_nxt.al = s_r.al & ~s_r.al_mask;
        end
      end else if (s_r.bitn == BIT_ACK) begin
        s_nxt.bitn = BIT_ZERO;
        s_nxt.sda_oe_n = 1'b1;
        s_nxt.st = s_r.nst;
        if (s_r.st == ST_ADRL && s_r.nst == ST_WDAT) begin
          // section copied to write buffer before data arrives
          for (int i = 0; i < 8; i++) begin
            s_nxt.wbuf[i] = rd_byte(s_r, {sec, 3'(i)}, s_r.tm);
          end
        end
        if (s_r.nst == ST_RDAT) begin
          // first data byte comes from a fresh snapshot
          if (s_r.st == ST_DEVA) begin
            s_nxt.rdl = s_r.tm;
            s_nxt.txb = rd_byte(s_r, s_r.addr, s_r.tm);
          end else begin
            // sequential read walks the section with wrap
            s_nxt.addr = addr_inc;
            s_nxt.txb = rd_byte(s_r, addr_inc, s_r.rdl);
          end
          s_nxt.al_mask = s_r.al;
          s_nxt.sda_oe_n = s_nxt.txb[7];
        end
      end else if (s_r.st == ST_RDAT && s_r.bitn != BIT_ZERO) begin
        // next bit driven on the serial clock fall
        s_nxt.txb = {s_r.txb[6:0], 1'b0};
        s_nxt.sda_oe_n = s_r.txb[6];
      end
    end

    // sticky alarm flags, a new hit wins over a clear
    s_nxt.al = s_nxt.al | hit;
    // open-drain interrupt pulled low while enabled flag stands
    s_nxt.irq_oe_n = ~(s_nxt.ctrl[CTRL_IRQ_EN] & |s_nxt.al);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.tm <= TM_RESET;
      s_r.rdl <= TM_RESET;
      s_r.wbuf <= TM_RESET;
      s_r.tpend <= TM_RESET;
      s_r.rtcf <= 1'b1;
      s_r.st <= ST_IDLE;
      s_r.nst <= ST_IDLE;
      s_r.scl_s <= 2'b11;
      s_r.sda_s <= 2'b11;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      s_r.sda_oe_n <= 1'b1;
      s_r.irq_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign OD_PINS.sda_o = 1'b0;
  assign OD_PINS.irq_o = 1'b0;
  assign OD_PINS.sda_oe_n = s_r.sda_oe_n;
  assign OD_PINS.irq_oe_n = s_r.irq_oe_n;
  assign BAT_SEL = s_r.bat;
  assign CRYSTAL_AMP_OUT = s_r.xo;
endmodule

// >>> test/rtc_host_model.sv
// two-wire host model that frames writes and reads
`timescale 1ns/1ps
module rtc_host_model (
  // phase reference
  input wire logic clk,
  // resolved data wire
  input wire logic sda,
  // host drives, data 1 releases the wire
  output logic scl,
  output logic sda_m
);
  import rtc_pkg::*;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start when a=1 b=0, stop when a=0 b=1
  task automatic cond(input logic a, input logic b);
    @(posedge clk);
    #42.7 sda_m = a;
    #40 scl = 1'b1;
    #40 sda_m = b;
    #40 scl = b;
  endtask
  task automatic bit1(input logic b, output logic r);
    #40 sda_m = b;
    #40 scl = 1'b1;
    #80 r = sda;
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic nk);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], q[i]);
    end
    bit1(a, nk);
  endtask
  task automatic wr(input logic [6:0] sel, input logic [7:0] a, input logic [55:0] d, input int n,
                    output logic nk);
    logic [79:0] f;
    logic [7:0] q;
    logic k;
    f = {sel, 1'b0, 8'h00, a, d};
    nk = 1'b0;
    cond(1'b1, 1'b0);
    for (int i = 0; i < n + 3; i++) begin
      xbyte(f[79:72], 1'b1, q, k);
      nk = nk | k;
      f = f << 8;
    end
    cond(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input int n, output logic [55:0] q);
    logic [7:0] b;
    logic k;
    q = '0;
    cond(1'b1, 1'b0);
    xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, b, k);
    xbyte(8'h00, 1'b1, b, k);
    xbyte(a, 1'b1, b, k);
    cond(1'b1, 1'b0);
    xbyte({DEV_ADDR_DEF, 1'b1}, 1'b1, b, k);
    for (int i = 0; i < n; i++) begin
      xbyte(8'hFF, i == n - 1, b, k);
      q = {q[47:0], b};
    end
    cond(1'b0, 1'b1);
  endtask
endmodule

// >>> test/rtc_timekeeper_bench.sv
// self-checking bench for the timekeeper core
`timescale 1ns/1ps
module rtc_timekeeper_bench;
  import rtc_pkg::*;
  localparam int XD = 4;
  localparam int NVC = 2000;
  localparam logic [55:0] SETS [4] = '{56'h59_59_A3_28_02_00_06, 56'h59_59_A3_28_02_01_03,
    56'h59_59_A3_30_04_05_00, 56'h59_59_31_31_12_99_05};
  localparam logic [55:0] ROLLS [4] = '{56'h00_00_80_29_02_00_00, 56'h00_00_80_01_03_01_04,
    56'h00_00_80_01_05_05_01, 56'h00_00_12_01_01_00_06};
  logic clk;
  logic rst_n;
  logic xtal;
  pwr_cmp_s pwr;
  logic bat;
  od_pins_s od;
  logic scl;
  logic sda_m;
  wire logic sda;
  logic [55:0] q;
  logic nk;
  int bad_count;
  int checks_done;
  assign sda = sda_m & od.sda_oe_n;
  rtc_timekeeper #(.XTAL_DIV(XD), .NV_CYCLES(NVC)) u_dut (.CLK(clk), .RST_N(rst_n), .SCL(scl),
    .SDA_I(sda), .CRYSTAL_AMP_IN(xtal), .CRYSTAL_AMP_OUT(), .PWR_CMP(pwr), .BAT_SEL(bat), .OD_PINS(od));
  rtc_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  always #4 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n * XD) begin
      repeat (4) @(posedge clk);
      xtal <= 1'b1;
      repeat (4) @(posedge clk);
      xtal <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic w1(input logic [7:0] a, input logic [7:0] b);
    u_host.wr(DEV_ADDR_DEF, a, {b, 48'h0}, 1, nk);
  endtask
  task automatic unlock();
    w1(8'h3F, SR_SET_WEL);
    w1(8'h3F, SR_SET_RWEL);
  endtask
  task automatic t_reset();
    chk({od.sda_oe_n, od.irq_oe_n, bat}, 3'b110);
    u_host.rd(8'h30, 7, q);
    chk(q, 56'h00_00_12_01_01_00_00);
    u_host.rd(8'h3F, 1, q);
    chk(q, 56'h01);
    ticks(2);
    u_host.rd(8'h30, 7, q);
    chk(q, 56'h00_00_12_01_01_00_00);
  endtask
  task automatic t_roll();
    unlock();
    for (int i = 0; i < 4; i++) begin
      u_host.wr(DEV_ADDR_DEF, 8'h30, SETS[i], 7, nk);
      chk(nk, 1'b0);
      ticks(1);
      u_host.rd(8'h30, 7, q);
      chk(q, SETS[i]);
      ticks(1);
      u_host.rd(8'h30, 7, q);
      chk(q, ROLLS[i]);
    end
    u_host.rd(8'h3F, 1, q);
    chk(q, 56'h06);
  endtask
  task automatic t_single_and_refuse();
    w1(8'h31, 8'h45);
    ticks(1);
    u_host.rd(8'h30, 7, q);
    chk(q, 56'h00_45_12_01_01_00_06);
    u_host.wr(7'h50, 8'h30, 56'h0, 1, nk);
    chk(nk, 1'b1);
    w1(8'h3F, SR_CLEAR);
    w1(8'h30, 8'h11);
    chk(nk, 1'b1);
    ticks(1);
    u_host.rd(8'h30, 7, q);
    chk(q, 56'h01_45_12_01_01_00_06);
  endtask
  task automatic t_alarm();
    unlock();
    w1(8'h10, 8'h80);
    w1(8'h3F, SR_SET_RWEL);
    chk(nk, 1'b1);
    repeat (NVC) @(posedge clk);
    unlock();
    w1(8'h00, 8'h82);
    chk(nk, 1'b0);
    repeat (NVC) @(posedge clk);
    chk(od.irq_oe_n, 1'b1);
    ticks(1);
    chk(od.irq_oe_n, 1'b0);
    u_host.rd(8'h3F, 1, q);
    chk(q, 56'h22);
    u_host.rd(8'h3F, 1, q);
    chk(q, 56'h02);
  endtask
  task automatic t_repeat();
    unlock();
    w1(8'h10, 8'hC0);
    repeat (NVC) @(posedge clk);
    unlock();
    w1(8'h08, 8'h84);
    repeat (NVC) @(posedge clk);
    ticks(2);
    u_host.rd(8'h3F, 1, q);
    chk(q, 56'h42);
    ticks(60);
    chk(od.irq_oe_n, 1'b0);
    u_host.rd(8'h3F, 1, q);
    chk(q, 56'h42);
  endtask
  task automatic t_supply();
    pwr <= 2'b10;
    repeat (8) @(posedge clk);
    chk(bat, 1'b1);
    pwr <= 2'b00;
    repeat (8) @(posedge clk);
    chk(bat, 1'b1);
    pwr <= 2'b01;
    repeat (8) @(posedge clk);
    chk(bat, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    xtal = 1'b0;
    pwr = 2'b00;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_roll();
    t_single_and_refuse();
    t_alarm();
    t_repeat();
    t_supply();
    tally_and_finish();
  end
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
bind rtc_timekeeper rtc_timekeeper_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_I(SDA_I),
  .CRYSTAL_AMP_IN(CRYSTAL_AMP_IN), .PWR_CMP(PWR_CMP), .CRYSTAL_AMP_OUT(CRYSTAL_AMP_OUT),
  .BAT_SEL(BAT_SEL), .OD_PINS(OD_PINS));

// >>> test/rtc_timekeeper_monitor.sv
// port assertions for the timekeeper core
`timescale 1ns/1ps
module rtc_timekeeper_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // inputs
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic CRYSTAL_AMP_IN,
  input rtc_pkg::pwr_cmp_s PWR_CMP,
  // outputs
  input wire logic CRYSTAL_AMP_OUT,
  input wire logic BAT_SEL,
  input rtc_pkg::od_pins_s OD_PINS
);
  import rtc_pkg::*;
  logic [3:0] low_r;
  // cycles since the serial clock went low, saturating
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_r <= 4'h0;
    end else begin
      low_r <= SCL ? 4'h0 : low_r + {3'h0, low_r != 4'hF};
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_below;
    PWR_CMP.below [*6];
  endsequence
  sequence s_above;
    (PWR_CMP.above && !PWR_CMP.below) [*6];
  endsequence
  a_idle_after_reset: assert property ($rose(RST_N) |-> OD_PINS.sda_oe_n && OD_PINS.irq_oe_n && !BAT_SEL)
    else $error("pins not idle after reset");
  a_sda_drive_zero: assert property (!OD_PINS.sda_o)
    else $error("data driver not open drain");
  a_irq_drive_zero: assert property (!OD_PINS.irq_o)
    else $error("interrupt driver not open drain");
  a_sda_after_fall: assert property ($changed(OD_PINS.sda_oe_n) |-> low_r inside {[4'h2:4'h6]})
    else $error("data drive changed away from clock fall");
  a_xtal_inverted: assert property ($stable(CRYSTAL_AMP_IN) [*5] |-> CRYSTAL_AMP_OUT != CRYSTAL_AMP_IN)
    else $error("amplifier output not inverted");
  a_bat_on_below: assert property (s_below |-> BAT_SEL)
    else $error("backup not selected");
  a_bat_off_above: assert property (s_above |-> !BAT_SEL)
    else $error("main not selected");
  a_bat_holds: assert property ((!PWR_CMP.above && !PWR_CMP.below) [*6] |-> $stable(BAT_SEL))
    else $error("supply choice moved without cause");
endmodule
